// [core/rail_pkg.sv]
// constants and types shared by the display rail sequencer
package rail_pkg;
  // register offsets; only the thermal reading offset is fixed by the part
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TEMP = 8'h01;
  localparam logic [7:0] A_ROOM = 8'h02;
  localparam logic [7:0] A_DLSB = 8'h03;
  localparam logic [7:0] A_GAPS = 8'h04;
  localparam logic [7:0] A_LOW = 8'h05;
  localparam logic [7:0] A_HD1 = 8'h06;
  localparam logic [7:0] A_HD2 = 8'h07;
  localparam logic [7:0] A_TLO = 8'h08;
  localparam logic [7:0] A_THI = 8'h09;
  localparam logic [7:0] A_MIN = 8'h0A;
  localparam logic [7:0] A_MAX = 8'h0B;
  localparam logic [7:0] A_CFG = 8'h0C;
  localparam logic [7:0] A_FLT = 8'h0D;
  localparam logic [7:0] A_BURN = 8'h0E;
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int DL_LSB = 4;
  localparam int DL_COMP = 5;
  localparam int CFG_ISENS = 0;
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam logic [9:0] CORE_OFF_MS = 10'd200;
  localparam logic [9:0] SAMPLE_MS = 10'd1000;
  localparam logic [9:0] OFF_MIN_MS = 10'd1;
  localparam logic [2:0] ILIM_MS = 3'd4;
  typedef enum logic [2:0] {
    IDLE = 3'b000, ON_RUN = 3'b001, ON_HOLD = 3'b010,
    OFF_RUN = 3'b011, CORE_WAIT = 3'b100, SHUT = 3'b101
  } st_e;
  typedef struct packed {
    logic [7:0] room;
    logic lsb;
    logic comp;
    logic [3:0] g1;
    logic [3:0] g2;
    logic [3:0] g3;
    logic [4:0] lo;
    logic [2:0] seq;
    logic [4:0] h1;
    logic [4:0] h2;
    logic [7:0] tlo;
    logic [7:0] thi;
    logic [7:0] vmin;
    logic [7:0] vmax;
    logic isens;
  } cfg_s;
  localparam cfg_s CFG_RST = '{room: 8'h00, lsb: 1'b0, comp: 1'b0, g1: 4'h0, g2: 4'h0,
    g3: 4'h0, lo: 5'h00, seq: 3'h2, h1: 5'h00, h2: 5'h00, tlo: 8'h00, thi: 8'hFF,
    vmin: 8'h00, vmax: 8'hFF, isens: 1'b0};
endpackage : rail_pkg

// [core/display_rail_sequencer.sv]
// display rail sequencer: rail order, common level code, compensation
`timescale 1ns/1ns
`default_nettype none
module display_rail_sequencer import rail_pkg::*; #(
  parameter int MS_CYCLES = MS_CYC
) (
  // clock and control
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  // pins and analog status
  input wire logic enable_pin,
  input wire logic alone_pin,
  input wire logic vcom_dev,
  input wire logic vcom_ilim,
  input wire logic [7:0] adc_code,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_nack,
  // rails and analog controls
  output logic pos_src_en,
  output logic neg_src_en,
  output logic gate_off_en,
  output logic gate_on_en,
  output logic vcom_en,
  output logic [8:0] vcom_code,
  output logic core_regulator,
  output logic int_sensor,
  output logic burn_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] rails_upto(input logic [2:0] s, input logic [2:0] n);
    logic [19:0] t;
    logic [4:0] r;
    r = 5'h00;
    case (s)
      3'h0: t = {5'h18, 5'h04, 5'h02, 5'h01};
      3'h1: t = {5'h14, 5'h08, 5'h02, 5'h01};
      3'h2: t = {5'h18, 5'h04, 5'h01, 5'h02};
      3'h3: t = {5'h14, 5'h08, 5'h01, 5'h02};
      3'h4: t = {5'h18, 5'h01, 5'h04, 5'h02};
      3'h5: t = {5'h11, 5'h02, 5'h08, 5'h04};
      3'h6: t = {5'h00, 5'h18, 5'h04, 5'h03};
      default: t = {5'h00, 5'h14, 5'h08, 5'h03};
    endcase
    for (int i = 0; i < 4; i++) begin
      if (3'(i) < n) r = r | t[i*5 +: 5];
    end
    return r;
  endfunction : rails_upto

  function automatic logic [9:0] gap_sel(input cfg_s c, input logic [2:0] i);
    case (i)
      3'h1: return {6'h00, c.g1};
      3'h2: return {6'h00, c.g2};
      3'h3: return {6'h00, c.g3};
      default: return 10'h000;
    endcase
  endfunction : gap_sel

  function automatic logic [8:0] comp_of(input cfg_s c, input logic [7:0] t);
    int d;
    int v;
    if (t <= c.tlo) d = -int'(c.lo);
    else if (t >= c.thi) begin
      if (c.thi == 8'hFF) d = int'(c.h1);
      else d = int'(c.h1) + int'(c.h2) * int'(t - c.thi) / (255 - int'(c.thi));
    end else begin
      d = -int'(c.lo) + (int'(c.lo) + int'(c.h1)) * int'(t - c.tlo)
        / int'(c.thi - c.tlo);
    end
    v = int'({c.room, c.lsb}) + d;
    if (v < 0) return 9'h000;
    if (v > 511) return 9'h1FF;
    return 9'(v);
  endfunction : comp_of

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: {ilim, dev, alone, enable}
  logic [3:0] s0, s1, s2, pf, pq;
  logic [3:0] next_pf;
  always_comb begin
    next_pf = (~(s1 ^ s2) & s2) | ((s1 ^ s2) & pf);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      s0 <= 4'h0;
      s1 <= 4'h0;
      s2 <= 4'h0;
      pf <= 4'h0;
      pq <= 4'h0;
    end else if (ce) begin
      s0 <= {vcom_ilim, vcom_dev, alone_pin, enable_pin};
      s1 <= s0;
      s2 <= s1;
      pf <= next_pf;
      pq <= pf;
    end
  end
  logic en_rise, en_fall;
  assign en_rise = pf[0] & ~pq[0];
  assign en_fall = ~pf[0] & pq[0];

  ////////////////////////////////////////////////////////////////////////////
  // register file
  cfg_s cfg, next_cfg;
  logic fault, next_fault, next_burn, trip;
  logic [7:0] next_rdata, thermal_reading;
  logic [4:0] rails;
  st_e st, next_st;
  logic wr_room;
  assign wr_room = reg_wr && reg_addr == A_ROOM;
  assign reg_nack = wr_room && !cfg.comp
    && (reg_wdata < cfg.vmin || reg_wdata > cfg.vmax);
  always_comb begin
    next_cfg = cfg;
    next_burn = reg_wr && reg_addr == A_BURN;
    next_rdata = reg_rdata;
    if (wr_room && !reg_nack) next_cfg.room = reg_wdata;
    if (reg_wr) begin
      case (reg_addr)
        A_DLSB: begin
          next_cfg.g3 = reg_wdata[3:0];
          next_cfg.lsb = reg_wdata[DL_LSB];
          next_cfg.comp = reg_wdata[DL_COMP];
        end
        A_GAPS: {next_cfg.g2, next_cfg.g1} = reg_wdata;
        A_LOW: {next_cfg.seq, next_cfg.lo} = reg_wdata;
        A_HD1: next_cfg.h1 = reg_wdata[4:0];
        A_HD2: next_cfg.h2 = reg_wdata[4:0];
        A_TLO: next_cfg.tlo = reg_wdata;
        A_THI: next_cfg.thi = reg_wdata;
        A_MIN: next_cfg.vmin = reg_wdata;
        A_MAX: next_cfg.vmax = reg_wdata;
        A_CFG: next_cfg.isens = reg_wdata[CFG_ISENS];
        default: next_cfg = next_cfg;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: next_rdata = {5'h00, st};
        A_TEMP: next_rdata = thermal_reading;
        A_ROOM: next_rdata = cfg.room;
        A_DLSB: next_rdata = {2'h0, cfg.comp, cfg.lsb, cfg.g3};
        A_GAPS: next_rdata = {cfg.g2, cfg.g1};
        A_LOW: next_rdata = {cfg.seq, cfg.lo};
        A_HD1: next_rdata = {3'h0, cfg.h1};
        A_HD2: next_rdata = {3'h0, cfg.h2};
        A_TLO: next_rdata = cfg.tlo;
        A_THI: next_rdata = cfg.thi;
        A_MIN: next_rdata = cfg.vmin;
        A_MAX: next_rdata = cfg.vmax;
        A_CFG: next_rdata = {7'h00, cfg.isens};
        A_FLT: next_rdata = {7'h00, fault};
        default: next_rdata = 8'h00;
      endcase
    end
    // set beats the read-clear; deviation is not monitored in the off sequence, current limit trip is
    next_fault = trip || (pf[2] && rails[4] && st != OFF_RUN)
      || (fault && !(reg_rd && reg_addr == A_FLT));
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg <= CFG_RST;
      fault <= 1'b0;
      reg_rdata <= 8'h00;
      burn_pulse <= 1'b0;
    end else if (ce) begin
      cfg <= next_cfg;
      fault <= next_fault;
      reg_rdata <= next_rdata;
      burn_pulse <= next_burn;
    end
  end
  assign int_sensor = cfg.isens;

  ////////////////////////////////////////////////////////////////////////////
  // power sequencer
  cfg_s cap, next_cap;
  logic [2:0] level, next_level, nsteps, ilc, next_ilc;
  logic [9:0] cnt, next_cnt;
  logic [14:0] pre, next_pre;
  logic [4:0] next_rails;
  logic tick, go, ld, start_req, stop_req;
  assign nsteps = cap.seq[2:1] == 2'b11 ? 3'd3 : 3'd4;
  assign tick = pre == 15'(MS_CYCLES - 1);
  assign start_req = (reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_START])
    || (pf[1] && en_rise);
  assign stop_req = (reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_STOP]) || en_fall;
  assign trip = pf[3] && ilc == ILIM_MS;
  always_comb begin
    next_st = st;
    next_level = level;
    next_cap = cap;
    next_cnt = cnt - {9'h000, tick && cnt != 10'h000};
    go = 1'b0;
    ld = 1'b0;
    next_ilc = !pf[3] ? 3'd0 : ilc + {2'b00, tick && ilc != ILIM_MS};
    case (st)
      IDLE: go = start_req;
      ON_RUN, ON_HOLD: begin
        if (stop_req) begin
          next_st = OFF_RUN;
          next_cnt = 10'h000;
        end else if (level == nsteps) next_st = ON_HOLD;
        else if (cnt == 10'h000) begin
          next_level = level + 3'd1;
          next_cnt = gap_sel(cap, level + 3'd1);
          ld = 1'b1;
        end
      end
      OFF_RUN: begin
        if (level == 3'd0) begin
          next_st = CORE_WAIT;
          next_cnt = CORE_OFF_MS;
          ld = 1'b1;
        end else if (cnt == 10'h000) begin
          next_level = level - 3'd1;
          next_cnt = gap_sel(cap, level - 3'd1 + 3'd4 - nsteps);
          if (next_cnt == 10'h000) next_cnt = OFF_MIN_MS;
          ld = 1'b1;
        end
      end
      CORE_WAIT: if (cnt == 10'h000) next_st = SHUT;
      SHUT: begin
        if (en_rise) begin
          next_st = IDLE;
          go = pf[1];
        end
      end
      default: next_st = IDLE;
    endcase
    if (go) begin
      next_cap = cfg;
      next_level = 3'd1;
      next_cnt = {6'h00, cfg.g1};
      next_st = ON_RUN;
      ld = 1'b1;
    end
    if (trip) begin
      next_level = 3'd0;
      next_st = IDLE;
      next_ilc = 3'd0;
    end
    next_pre = (ld || tick) ? 15'h0000 : pre + 15'h0001;
    next_rails = rails_upto(next_cap.seq, next_level);
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= IDLE;
      level <= 3'd0;
      cap <= CFG_RST;
      cnt <= 10'h000;
      pre <= 15'h0000;
      ilc <= 3'd0;
      rails <= 5'h00;
    end else if (ce) begin
      st <= next_st;
      level <= next_level;
      cap <= next_cap;
      cnt <= next_cnt;
      pre <= next_pre;
      ilc <= next_ilc;
      rails <= next_rails;
    end
  end
  assign {vcom_en, gate_on_en, gate_off_en, neg_src_en, pos_src_en} = rails;
  assign core_regulator = st != SHUT;

  ////////////////////////////////////////////////////////////////////////////
  // temperature compensation, free millisecond base so sequencing never skews it
  logic [14:0] fpre, next_fpre;
  logic [9:0] sc, next_sc;
  logic [8:0] comp_code, next_comp, next_vcom;
  logic [7:0] next_therm;
  logic cvalid, next_cvalid, ftick, sample;
  assign ftick = fpre == 15'(MS_CYCLES - 1);
  assign sample = cfg.comp && ftick && sc == SAMPLE_MS - 10'd1;
  always_comb begin
    next_fpre = ftick ? 15'h0000 : fpre + 15'h0001;
    next_sc = !cfg.comp || sample ? 10'h000 : sc + {9'h000, ftick};
    next_therm = sample ? adc_code : thermal_reading;
    next_comp = sample ? comp_of(cfg, adc_code) : comp_code;
    next_cvalid = (cvalid || sample) && cfg.comp && st != SHUT;
    // code to volts is linear: code * 6.83 mV - 2.49 V
    next_vcom = (cvalid && cfg.comp) ? comp_code : {cfg.room, cfg.lsb};
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      fpre <= 15'h0000;
      sc <= 10'h000;
      thermal_reading <= 8'h00;
      comp_code <= 9'h000;
      cvalid <= 1'b0;
      vcom_code <= 9'h000;
    end else if (ce) begin
      fpre <= next_fpre;
      sc <= next_sc;
      thermal_reading <= next_therm;
      comp_code <= next_comp;
      cvalid <= next_cvalid;
      vcom_code <= next_vcom;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  hold_order_a: assert property (st == ON_HOLD |-> rails == rails_upto(cap.seq, nsteps))
    else $error("rails wrong in hold");
  three_step_a: assert property (st == ON_HOLD && cap.seq[2:1] == 2'b11 |-> level == 3'd3)
    else $error("three-step code wrong length");
  zero_gap_a: assert property (ce && st == ON_RUN && cnt == 10'h000 && level < nsteps
    && !stop_req && !trip |=> level == $past(level) + 3'd1)
    else $error("zero gap did not advance");
  off_gap_a: assert property (ce && st == OFF_RUN && level > 3'd1 && cnt == 10'h000
    && !trip |=> cnt >= OFF_MIN_MS)
    else $error("off gap below one ms");
  core_off_a: assert property (ce && st == CORE_WAIT && cnt == 10'h000 && !trip
    |=> !core_regulator)
    else $error("core regulator stayed on");
  limit_trip_a: assert property (ce && trip |=> rails == 5'h00 && fault)
    else $error("limit fault did not drop rails");
  nack_keep_a: assert property (ce && reg_nack |=> cfg.room == $past(cfg.room))
    else $error("refused write changed level");
  dev_flag_a: assert property (ce && pf[2] && rails[4] && st != OFF_RUN |=> fault)
    else $error("deviation not flagged");
  sample_a: assert property (ce && sample |=> thermal_reading == $past(adc_code))
    else $error("reading not stored");
  start_code_a: assert property (!cvalid |=> vcom_code == $past({cfg.room, cfg.lsb}))
    else $error("uncompensated code not driven");
  full_on_c: cover property (st == ON_HOLD);
  shut_c: cover property (st == SHUT);
  comp_c: cover property (cvalid && sample);
  trip_c: cover property (trip && rails != 5'h00);
endmodule : display_rail_sequencer
`default_nettype wire

// [test/reg_host.sv]
// register host model driving the sequencer's register port
`timescale 1ns/1ns
`default_nettype none
module reg_host (
  // clock
  input wire logic clock,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_nack
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one strobe cycle; lines inverted afterwards so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nack);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    #10;
    nack = reg_nack;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask : rd
endmodule : reg_host
`default_nettype wire

// [test/display_rail_sequencer_tb.sv]
// self-checking bench for the display rail sequencer
`timescale 1ns/1ns
`default_nettype none
module display_rail_sequencer_tb;
  import rail_pkg::*;
  localparam int M = 8;
  // new rails per step, {pos,neg,goff,gon} nibbles, first step on top
  localparam logic [15:0] tbl [8] = '{16'h8421, 16'h8412, 16'h4821, 16'h4812,
    16'h4281, 16'h2148, 16'hC210, 16'hC120};
  logic clock = 1'b0, rst = 1'b1, enable_pin = 1'b1, vcom_dev = 1'b0, vcom_ilim = 1'b0;
  logic [7:0] adc_code = 8'h00;
  logic alone_pin = 1'b0;
  logic reg_wr, reg_rd, reg_nack, pos_src_en, neg_src_en, gate_off_en, gate_on_en, vcom_en;
  logic core_regulator, int_sensor, burn_pulse, nk;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [8:0] vcom_code;
  logic [2:0] hits;
  int errors = 0, compares = 0, c;
  wire logic [3:0] rails = {pos_src_en, neg_src_en, gate_off_en, gate_on_en};

  display_rail_sequencer #(.MS_CYCLES(M)) i_dut (.clock, .rst, .ce(1'b1), .enable_pin,
    .alone_pin, .vcom_dev, .vcom_ilim, .adc_code, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_nack, .pos_src_en, .neg_src_en, .gate_off_en, .gate_on_en,
    .vcom_en, .vcom_code, .core_regulator, .int_sensor, .burn_pulse);
  reg_host i_host (.clock, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_nack);

  initial begin
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic chk_n(input string n, input int e, input int g, input int tol);
    compares++;
    if (g < e - tol || g > e + tol) begin
      errors++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_n
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    i_host.wr(a, d, nk);
  endtask : w
  task automatic r(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, rv);
    chk($sformatf("reg %h", a), e, rv);
  endtask : r
  // counts cycles until rails leave prev; a hang ends the run
  task automatic wait_rails(input logic [3:0] prev, output int n);
    n = 0;
    while (rails === prev) begin
      @(negedge clock);
      n++;
      if (n > 2000 * M) begin
        errors++;
        results();
      end
    end
  endtask : wait_rails
  task automatic wait_code(input logic [8:0] v, output int n);
    n = 0;
    while (vcom_code === v) begin
      @(negedge clock);
      n++;
      if (n > 1100 * M) begin
        errors++;
        results();
      end
    end
  endtask : wait_code
  ////////////////////////////////////////////////////////////////////////////////
  task automatic run_seq(input logic [2:0] code, input logic [3:0] g1, g2, g3);
    logic [3:0] cum, g [3];
    int n, gi;
    n = (code[2] & code[1]) ? 3 : 4;
    g = '{g1, g2, g3};
    cum = 4'h0;
    w(A_LOW, {code, 5'h00});
    w(A_GAPS, {g2, g1});
    w(A_DLSB, {4'h0, g3});
    w(A_CTRL, 8'h01);
    for (int k = 0; k < n; k++) begin
      wait_rails(cum, c);
      cum |= tbl[code][15-4*k -: 4];
      chk("rails on", cum, rails);
      chk("level on", k == n - 1, vcom_en);
      if (k > 0) chk_n("on gap", g[k-1] == 0 ? 1 : g[k-1] * M, c, 2);
    end
    w(A_CTRL, 8'h02);
    for (int k = n - 1; k >= 0; k--) begin
      wait_rails(cum, c);
      cum &= ~tbl[code][15-4*k -: 4];
      chk("rails off", cum, rails);
      chk("level off", 1'b0, vcom_en);
      gi = (n == 4) ? k : k + 1;
      if (k < n - 1) chk_n("off gap", g[gi] == 0 ? M : g[gi] * M, c, 2);
    end
    c = 0;
    while (core_regulator === 1'b1 && c < 300 * M) begin
      @(negedge clock);
      c++;
    end
    chk_n("core off", 200 * M, c, M + 2);
    w(A_CTRL, 8'h01);
    repeat (3) @(negedge clock);
    chk("shut start", 4'h0, rails);
    enable_pin = 1'b0;
    repeat (6) @(negedge clock);
    enable_pin = 1'b1;
    repeat (8) @(negedge clock);
    chk("core on", 1'b1, core_regulator);
  endtask : run_seq
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #5000000;
    errors++;
    results();
  end
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    r(A_LOW, 8'h40);
    r(A_THI, 8'hFF);
    r(A_MAX, 8'hFF);
    r(A_CFG, 8'h00);
    r(8'h20, 8'h00);
    chk("core reset", 1'b1, core_regulator);
    w(A_MAX, 8'h10);
    i_host.wr(A_ROOM, 8'h20, nk);
    chk("nack high", 1'b1, nk);
    r(A_ROOM, 8'h00);
    i_host.wr(A_ROOM, 8'h08, nk);
    chk("nack low", 1'b0, nk);
    w(A_DLSB, 8'h10);
    @(negedge clock);
    chk("level code", 9'h011, vcom_code);
    w(A_CFG, 8'h01);
    chk("sensor", 1'b1, int_sensor);
    w(A_MAX, 8'hFF);
    w(A_BURN, 8'h01);
    hits = {2'b00, burn_pulse};
    repeat (3) begin
      @(negedge clock);
      hits = hits + burn_pulse;
    end
    chk("burn pulse", 3'd1, hits);
    for (int k = 0; k < 8; k++) run_seq(3'(k), 4'h0, 4'h0, 4'h0);
    run_seq(3'h5, 4'h1, 4'h2, 4'h3);
    // deviation flag with rails up, then current limit trip
    w(A_LOW, 8'h40);
    w(A_GAPS, 8'h00);
    w(A_DLSB, 8'h00);
    w(A_CTRL, 8'h01);
    repeat (8) @(negedge clock);
    vcom_dev = 1'b1;
    repeat (6) @(negedge clock);
    vcom_dev = 1'b0;
    repeat (6) @(negedge clock);
    chk("level kept", 1'b1, vcom_en);
    r(A_FLT, 8'h01);
    r(A_FLT, 8'h00);
    vcom_ilim = 1'b1;
    wait_rails(4'hF, c);
    chk_n("trip time", 4 * M, c, M + 5);
    chk("level trip", 1'b0, vcom_en);
    vcom_ilim = 1'b0;
    r(A_FLT, 8'h01);
    r(A_CTRL, 8'h00);
    // compensation at the high point, then back at the low point
    w(A_ROOM, 8'h20);
    w(A_HD1, 8'h05);
    adc_code = 8'hFF;
    w(A_DLSB, 8'h20);
    @(negedge clock);
    chk("room level", 9'h040, vcom_code);
    wait_code(9'h040, c);
    chk("comp high", 9'h045, vcom_code);
    r(A_TEMP, 8'hFF);
    adc_code = 8'h00;
    wait_code(9'h045, c);
    chk("comp low", 9'h040, vcom_code);
    chk_n("sample period", 1000 * M, c, 2);
    r(A_TEMP, 8'h00);
    // stand-alone start: enable rise alone brings up the first step
    alone_pin = 1'b1;
    enable_pin = 1'b0;
    repeat (6) @(negedge clock);
    enable_pin = 1'b1;
    wait_rails(4'h0, c);
    chk("alone start", 4'h4, rails);
    results();
  end
endmodule : display_rail_sequencer_tb
`default_nettype wire
